// >>> bench/wcc_chopper_asserts.sv
module wcc_chopper_asserts
   import wcc_pkg::*;
#(
   parameter int PWM_PERIOD = PWM_CYCLES,
   parameter int BLANK_LEN = BLANK_CYCLES,
   parameter int OCP_QUAL = OCP_QUAL_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic logic_clear_n_i,
   input wire logic bridge_enable_i,
   input wire logic ocp_limit_i,
   input wire logic winding_out_a_o,
   input wire logic winding_out_a_oe_o,
   input wire logic winding_out_b_o,
   input wire logic winding_out_b_oe_o,
   input wire logic high_side_a_o,
   input wire logic low_side_a_o,
   input wire logic high_side_b_o,
   input wire logic low_side_b_o,
   input wire logic trip_flag_n_oe_o,
   input wire logic [1:0] decay_mode_o,
   input wire logic [1:0] chop_phase_o,
   input wire logic blanking_o,
   input wire logic pwm_cycle_start_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // Helper counters; quiet, gap and ocnt saturate so a long idle spell cannot wrap, blen does not
   logic [15:0] quiet, gap, blen, ocnt;
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || !logic_clear_n_i || !bridge_enable_i) quiet <= 16'h0000;
      else if (quiet != 16'hffff) quiet <= quiet + 16'h0001;
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || pwm_cycle_start_o) gap <= 16'h0000;
      else if (gap != 16'hffff) gap <= gap + 16'h0001;
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || !blanking_o) blen <= 16'h0000;
      else blen <= blen + 16'h0001;
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || !ocp_limit_i) ocnt <= 16'h0000;
      else if (ocnt != 16'hffff) ocnt <= ocnt + 16'h0001;
   end
   // ==========
   // Properties
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_off;
      (!bridge_enable_i)[*4];
   endsequence
   sequence s_slow3;
      (chop_phase_o == WCC_ST_SLOW)[*3];
   endsequence
   pin_level_a: assert property (winding_out_a_o == high_side_a_o && winding_out_b_o == high_side_b_o
      && winding_out_a_oe_o == (high_side_a_o || low_side_a_o) && winding_out_b_oe_o == (high_side_b_o || low_side_b_o)
      && (!(winding_out_a_oe_o || winding_out_b_oe_o) || $past(bridge_enable_i, 3)))
      else $error("pin level disagrees with gates");
   diag_pair_a: assert property (!(high_side_a_o && !low_side_b_o) && !(high_side_b_o && !low_side_a_o))
      else $error("high side on without opposite low side");
   disabled_hiz_a: assert property (s_off |=> !winding_out_a_oe_o && !winding_out_b_oe_o)
      else $error("outputs driven while disabled");
   clear_off_a: assert property ((!logic_clear_n_i)[*4] |=> !trip_flag_n_oe_o && !winding_out_a_oe_o && !winding_out_b_oe_o)
      else $error("clear did not stop bridge");
   slow_lows_a: assert property (s_slow3 ##0 (quiet > 8 && !trip_flag_n_oe_o)
      |-> $past(low_side_a_o && low_side_b_o && !high_side_a_o && !high_side_b_o)) else $error("slow decay gates wrong");
   blank_len_a: assert property ($fell(blanking_o) && quiet > BLANK_LEN + 4 && !trip_flag_n_oe_o |-> blen == BLANK_LEN)
      else $error("blanking length wrong");
   period_gap_a: assert property (pwm_cycle_start_o && quiet > PWM_PERIOD + 4 && !trip_flag_n_oe_o
      |-> gap == PWM_PERIOD - 1) else $error("period length wrong");
   mode_hold_a: assert property ($changed(decay_mode_o) && quiet > 4 |-> pwm_cycle_start_o)
      else $error("decay mode changed mid period");
   fault_set_a: assert property (ocnt > OCP_QUAL + 4 && quiet > OCP_QUAL + 4
      |-> trip_flag_n_oe_o && !winding_out_a_oe_o && !winding_out_b_oe_o) else $error("current limit not latched");
   fault_hold_a: assert property (trip_flag_n_oe_o && logic_clear_n_i && $past(logic_clear_n_i)
      && $past(logic_clear_n_i, 2) && $past(logic_clear_n_i, 3) |=> trip_flag_n_oe_o) else $error("fault released early");
endmodule

bind wcc_chopper wcc_chopper_asserts #(.PWM_PERIOD(PWM_PERIOD), .BLANK_LEN(BLANK_LEN), .OCP_QUAL(OCP_QUAL)) u_asserts (
   .core_clk_i(core_clk_i),
   .rst_b_i(rst_b_i),
   .logic_clear_n_i(logic_clear_n_i),
   .bridge_enable_i(bridge_enable_i),
   .ocp_limit_i(ocp_limit_i),
   .winding_out_a_o(winding_out_a_o),
   .winding_out_a_oe_o(winding_out_a_oe_o),
   .winding_out_b_o(winding_out_b_o),
   .winding_out_b_oe_o(winding_out_b_oe_o),
   .high_side_a_o(high_side_a_o),
   .low_side_a_o(low_side_a_o),
   .high_side_b_o(high_side_b_o),
   .low_side_b_o(low_side_b_o),
   .trip_flag_n_oe_o(trip_flag_n_oe_o),
   .decay_mode_o(decay_mode_o),
   .chop_phase_o(chop_phase_o),
   .blanking_o(blanking_o),
   .pwm_cycle_start_o(pwm_cycle_start_o)
);

// >>> bench/wcc_winding_model.sv
module wcc_winding_model
   import wcc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic dir_i,
   input wire logic [2:0] rise_i,
   input wire logic hs_a_i,
   input wire logic ls_a_i,
   input wire logic hs_b_i,
   input wire logic ls_b_i,
   input wire logic [PCT_W-1:0] pct_i,
   output logic trip_o,
   output logic zero_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // Winding current; rise_i sets a prompt or sluggish load
   int cur = 0;
   logic fwd, rev;
   assign fwd = dir_i ? (hs_a_i && ls_b_i) : (hs_b_i && ls_a_i);
   assign rev = dir_i ? (hs_b_i && ls_a_i) : (hs_a_i && ls_b_i);
   always @(posedge core_clk_i) begin
      if (fwd) cur <= cur + int'(rise_i);
      else cur <= (cur > 3) ? cur - (rev ? 3 : 1) : 0;
   end
   assign trip_o = (cur * 5) > int'(pct_i);
   assign zero_o = cur < 2;
endmodule

// >>> bench/winding_chopper_control_bench.sv
module winding_chopper_control_bench
   import wcc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int P = 40;
   localparam int M = 30;
   localparam int B = 8;
   localparam int Q = 4;
   localparam logic [255:0] LVL_TAB = 256'h6464636261605e5c5a585653504d4a47433f3c38332f2b26221d18140f0a0500;
   logic clk = 1'b0, rst_b = 1'b0, clr_n = 1'b1, en = 1'b0, dir = 1'b0, rl = 1'b0, rh = 1'b0, ocp = 1'b0;
   logic [4:0] lvl = 5'h00;
   logic [2:0] rise = 3'h1;
   logic [6:0] pct;
   logic [1:0] mode, phase;
   logic outa, oea, outb, oeb, hsa, lsa, hsb, lsb, tfn, tfoe, blank, pstart, trip, zero;
   logic [31:0] seed = 32'h9e35;
   logic [3:0] seen;
   int fails = 0, cmp_count = 0, n, early;
   always #5 clk = ~clk;
   wcc_chopper #(.PWM_PERIOD(P), .BLANK_LEN(B), .MIX_AT(M), .OCP_QUAL(Q)) dut (.core_clk_i(clk), .rst_b_i(rst_b),
      .logic_clear_n_i(clr_n), .bridge_enable_i(en), .current_direction_i(dir), .current_level_select_i(lvl),
      .recirc_above_low_i(rl), .recirc_above_high_i(rh), .chop_trip_i(trip), .current_near_zero_i(zero),
      .ocp_limit_i(ocp), .ref_scale_pct_o(pct), .winding_out_a_o(outa), .winding_out_a_oe_o(oea),
      .winding_out_b_o(outb), .winding_out_b_oe_o(oeb), .high_side_a_o(hsa), .low_side_a_o(lsa),
      .high_side_b_o(hsb), .low_side_b_o(lsb), .trip_flag_n_o(tfn), .trip_flag_n_oe_o(tfoe),
      .decay_mode_o(mode), .chop_phase_o(phase), .blanking_o(blank), .pwm_cycle_start_o(pstart));
   wcc_winding_model u_load (.core_clk_i(clk), .dir_i(dir), .rise_i(rise), .hs_a_i(hsa), .ls_a_i(lsa),
      .hs_b_i(hsb), .ls_b_i(lsb), .pct_i(pct), .trip_o(trip), .zero_o(zero));
   // ==========
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [6:0] exp_pct(input logic [4:0] c);
      return LVL_TAB[int'(c) * 8 +: 7];
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic check(input string name, input logic [6:0] seen_v, input logic [6:0] exp_v);
      cmp_count++;
      if (seen_v !== exp_v) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp_v, seen_v);
      end
   endtask
   task automatic wait_start;
      n = 0;
      tick(1);
      while (pstart !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      check("start", 7'(pstart), 7'h01);
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========
   // Scenarios
   initial begin
      #200000;
      fails++;
      end_sim();
   end
   initial begin
      tick(5);
      rst_b = 1'b1;
      tick(3);
      for (int i = 0; i < 48; i++) begin
         seed = xs(seed);
         lvl = (i < 32) ? 5'(i) : seed[4:0];
         tick(4);
         check("level", pct, exp_pct(lvl));
      end
      lvl = 5'h1f;
      // Slow, fast, then the open-pin code and the impossible code, both of which must read as mixed
      for (int m = 0; m < 4; m++) begin
         seed = xs(seed);
         {rl, rh} = (m == 0) ? 2'b00 : (m == 1) ? 2'b11 : (m == 2) ? 2'b10 : 2'b01;
         dir = seed[0];
         rise = (m == 2) ? 3'h3 : 3'h1;
         en = 1'b1;
         wait_start();
         wait_start();
         // Gates follow the state one edge after the period starts
         tick(1);
         check("drive", {1'b0, outa, outb, hsa, lsb, hsb, lsa}, {1'b0, dir, !dir, dir, dir, !dir, !dir});
         seen = 4'h0;
         early = 0;
         for (int c = 0; c < 2 * P; c++) begin
            seen[phase] = 1'b1;
            if (mode == WCC_DECAY_MIXED && phase == WCC_ST_SLOW && (c % P) < M) early = 1;
            tick(1);
         end
         check("mode", 7'(mode), (m == 0) ? 7'h00 : (m == 1) ? 7'h03 : 7'h01);
         check("fast", 7'(seen[WCC_ST_FAST]), 7'(m != 0));
         check("slow", 7'(seen[WCC_ST_SLOW]), 7'(m != 1));
         check("early", 7'(early), 7'h00);
      end
      en = 1'b0;
      tick(5);
      check("hiz", {5'h00, oea, oeb}, 7'h00);
      en = 1'b1;
      tick(10);
      ocp = 1'b1;
      tick(Q + 6);
      check("fault", {3'h0, tfoe, tfn, oea, oeb}, 7'h08);
      ocp = 1'b0;
      tick(8);
      check("latch", 7'(tfoe), 7'h01);
      clr_n = 1'b0;
      tick(5);
      check("clear", {3'h0, tfoe, hsa, lsa, hsb | lsb}, 7'h00);
      clr_n = 1'b1;
      wait_start();
      tick(2);
      check("resume", {5'h00, oea, oeb}, 7'h03);
      rst_b = 1'b0;
      tick(3);
      rst_b = 1'b1;
      check("rst", {mode, phase, tfoe, oea, oeb}, 7'h20);
      wait_start();
      tick(2);
      check("restart", {5'h00, oea, oeb}, 7'h03);
      end_sim();
   end
endmodule

// >>> inc/wcc_pkg.sv
package wcc_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_FREQ_KHZ = 100000;
   localparam int PWM_FREQ_KHZ = 50;
   localparam int PWM_CYCLES = CLK_FREQ_KHZ / PWM_FREQ_KHZ;
   // Least time: rounded up to whole cycles
   localparam int BLANK_NS = 3750;
   localparam int BLANK_CYCLES = (BLANK_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int MIX_PERCENT = 75;
   localparam int MIX_CYCLES = (PWM_CYCLES * MIX_PERCENT) / 100;
   // Qualification time of the current limit; value not fixed by the part
   localparam int OCP_QUAL_NS = 3000;
   localparam int OCP_QUAL_CYCLES = (OCP_QUAL_NS * CLK_FREQ_KHZ + 999999) / 1000000;

   // ==========================================================
   // Input bundle layout on the synchroniser
   // ==========================================================
   localparam int SYNC_W = 13;
   localparam int IN_ENABLE = 0;
   localparam int IN_DIR = 1;
   localparam int IN_LEVEL_LSB = 2;
   localparam int LEVEL_W = 5;
   localparam int IN_RC_LOW = 7;
   localparam int IN_RC_HIGH = 8;
   localparam int IN_TRIP = 9;
   localparam int IN_ZERO = 10;
   localparam int IN_OCP = 11;
   localparam int IN_CLEAR_N = 12;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h0000;

   localparam int PCT_W = 7;
   localparam logic [PCT_W-1:0] PCT_RESET = 7'h00;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      WCC_DECAY_SLOW  = 2'b00,
      WCC_DECAY_MIXED = 2'b01,
      WCC_DECAY_FAST  = 2'b11
   } wcc_decay_t;

   // Gray order along drive -> fast -> slow -> off
   typedef enum logic [1:0] {
      WCC_ST_DRIVE = 2'b00,
      WCC_ST_FAST  = 2'b01,
      WCC_ST_SLOW  = 2'b11,
      WCC_ST_OFF   = 2'b10
   } wcc_state_t;

   // Percent of full-scale reference for each level code
   function automatic logic [PCT_W-1:0] wcc_level_pct(input logic [LEVEL_W-1:0] code);
      logic [PCT_W-1:0] pct;
      pct = 7'h00;
      case (code)
         5'h00: pct = 7'd0;
         5'h01: pct = 7'd5;
         5'h02: pct = 7'd10;
         5'h03: pct = 7'd15;
         5'h04: pct = 7'd20;
         5'h05: pct = 7'd24;
         5'h06: pct = 7'd29;
         5'h07: pct = 7'd34;
         5'h08: pct = 7'd38;
         5'h09: pct = 7'd43;
         5'h0a: pct = 7'd47;
         5'h0b: pct = 7'd51;
         5'h0c: pct = 7'd56;
         5'h0d: pct = 7'd60;
         5'h0e: pct = 7'd63;
         5'h0f: pct = 7'd67;
         5'h10: pct = 7'd71;
         5'h11: pct = 7'd74;
         5'h12: pct = 7'd77;
         5'h13: pct = 7'd80;
         5'h14: pct = 7'd83;
         5'h15: pct = 7'd86;
         5'h16: pct = 7'd88;
         5'h17: pct = 7'd90;
         5'h18: pct = 7'd92;
         5'h19: pct = 7'd94;
         5'h1a: pct = 7'd96;
         5'h1b: pct = 7'd97;
         5'h1c: pct = 7'd98;
         5'h1d: pct = 7'd99;
         default: pct = 7'd100;
      endcase
      return pct;
   endfunction

endpackage

// >>> src/wcc_chopper.sv
// Functional notes
// - Bridge enable low puts both winding outputs in high impedance.
// - Enabled, direction high drives A high, B low; low is reversed.
// - Each PWM period starts driving; a trip stops drive until next period.
// - Trip input is the comparator of five times sense against scaled reference.
// - Five level bits pick one of 32 reference scalings, top two full scale.
// - Fast decay reverses drive, then disables bridge near zero current.
// - Slow decay turns both low sides on, both high sides off.
// - Recirculation select low slow, open mixed, high fast.
// - Undriven recirculation select resolves to mixed decay.
// - Mixed decay is fast after trip, then slow from 75% of period.
// - Undriven enable, direction and level pins read low.
// - Comparator ignored for 3.75 us blanking after drive starts.
// - Logic clear low resets logic, disables drivers, ignores inputs.
// - Persistent current limit latches all switches off and pulls fault low.
module wcc_chopper
   import wcc_pkg::*;
#(
   parameter int PWM_PERIOD = PWM_CYCLES,
   parameter int BLANK_LEN = BLANK_CYCLES,
   parameter int MIX_AT = MIX_CYCLES,
   parameter int OCP_QUAL = OCP_QUAL_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic logic_clear_n_i,
   input wire logic bridge_enable_i,
   input wire logic current_direction_i,
   input wire logic [LEVEL_W-1:0] current_level_select_i,
   input wire logic recirc_above_low_i,
   input wire logic recirc_above_high_i,
   input wire logic chop_trip_i,
   input wire logic current_near_zero_i,
   input wire logic ocp_limit_i,
   output logic [PCT_W-1:0] ref_scale_pct_o,
   output logic winding_out_a_o,
   output logic winding_out_a_oe_o,
   output logic winding_out_b_o,
   output logic winding_out_b_oe_o,
   output logic high_side_a_o,
   output logic low_side_a_o,
   output logic high_side_b_o,
   output logic low_side_b_o,
   output logic trip_flag_n_o,
   output logic trip_flag_n_oe_o,
   output logic [1:0] decay_mode_o,
   output logic [1:0] chop_phase_o,
   output logic blanking_o,
   output logic pwm_cycle_start_o
);

   localparam int CNT_W = $clog2(PWM_PERIOD + 1);
   localparam int OCP_W = $clog2(OCP_QUAL + 1);
   localparam logic [CNT_W-1:0] PWM_LAST = CNT_W'(PWM_PERIOD - 1);
   localparam logic [CNT_W-1:0] BLANK_END = CNT_W'(BLANK_LEN);
   localparam logic [CNT_W-1:0] MIX_POINT = CNT_W'(MIX_AT);
   localparam logic [OCP_W-1:0] OCP_END = OCP_W'(OCP_QUAL);

   // ==========================================================
   // Parameter checks
   // ==========================================================
   if (BLANK_LEN < 1 || BLANK_LEN + 2 > PWM_PERIOD) begin : g_bad_blank
      $error("Blanking length must fit inside the PWM period");
   end
   if (MIX_AT <= BLANK_LEN || MIX_AT >= PWM_PERIOD) begin : g_bad_mix
      $error("Mixed decay switch point must lie between blanking and period end");
   end
   if (OCP_QUAL < 1) begin : g_bad_ocp
      $error("Current limit qualification must be at least one cycle");
   end

   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   logic [SYNC_W-1:0] pins_async;
   logic [SYNC_W-1:0] pins;

   always_comb begin
      pins_async = '0;
      pins_async[IN_ENABLE] = bridge_enable_i;
      pins_async[IN_DIR] = current_direction_i;
      pins_async[IN_LEVEL_LSB +: LEVEL_W] = current_level_select_i;
      pins_async[IN_RC_LOW] = recirc_above_low_i;
      pins_async[IN_RC_HIGH] = recirc_above_high_i;
      pins_async[IN_TRIP] = chop_trip_i;
      pins_async[IN_ZERO] = current_near_zero_i;
      pins_async[IN_OCP] = ocp_limit_i;
      pins_async[IN_CLEAR_N] = logic_clear_n_i;
   end

   wcc_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .async_i(pins_async),
      .sync_o(pins)
   );

   logic en_s;
   logic dir_s;
   logic [LEVEL_W-1:0] level_s;
   logic trip_s;
   logic zero_s;
   logic ocp_s;
   logic clear_act;

   // Clear held low by the synchroniser reset, so logic starts cleared
   assign clear_act = !pins[IN_CLEAR_N];
   // Pulled-down pins arrive low: bridge off, zero current
   assign en_s = pins[IN_ENABLE];
   assign dir_s = pins[IN_DIR];
   assign level_s = pins[IN_LEVEL_LSB +: LEVEL_W];
   assign trip_s = pins[IN_TRIP];
   assign zero_s = pins[IN_ZERO];
   assign ocp_s = pins[IN_OCP];

   // ==========================================================
   // Recirculation select decode
   // ==========================================================
   wcc_decay_t rc_decoded;
   wcc_decay_t decay_mode;

   // Mid level (open pin) and the impossible 01 code both map to mixed
   always_comb begin
      if (pins[IN_RC_HIGH] && pins[IN_RC_LOW]) begin
         rc_decoded = WCC_DECAY_FAST;
      end else if (!pins[IN_RC_HIGH] && !pins[IN_RC_LOW]) begin
         rc_decoded = WCC_DECAY_SLOW;
      end else begin
         rc_decoded = WCC_DECAY_MIXED;
      end
   end

   // ==========================================================
   // PWM period counter
   // ==========================================================
   logic [CNT_W-1:0] pwm_cnt;
   logic en_d;
   logic en_rise;
   logic period_start;
   logic fault;
   logic run;

   assign run = en_s && !fault && !clear_act;
   assign en_rise = run && !en_d;
   assign period_start = run && (en_rise || pwm_cnt == PWM_LAST);

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act) begin
         en_d <= 1'b0;
      end else begin
         en_d <= run;
      end
   end

   // Restart on enable so the first period is a full one
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act || en_rise) begin
         pwm_cnt <= '0;
      end else if (pwm_cnt == PWM_LAST) begin
         pwm_cnt <= '0;
      end else begin
         pwm_cnt <= pwm_cnt + CNT_W'(1);
      end
   end

   // Mode changes land at a period boundary, or go to mixed on clear or reset
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act) begin
         decay_mode <= WCC_DECAY_MIXED;
      end else if (period_start) begin
         decay_mode <= rc_decoded;
      end
   end

   // ==========================================================
   // Blanking window
   // ==========================================================
   logic [CNT_W-1:0] blank_cnt;
   logic blank_done;

   assign blank_done = (blank_cnt >= BLANK_END);

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act || period_start) begin
         blank_cnt <= '0;
      end else if (!blank_done) begin
         blank_cnt <= blank_cnt + CNT_W'(1);
      end
   end

   // ==========================================================
   // Current limit qualification and latch
   // ==========================================================
   logic [OCP_W-1:0] ocp_cnt;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act || !ocp_s) begin
         ocp_cnt <= '0;
      end else if (ocp_cnt != OCP_END) begin
         ocp_cnt <= ocp_cnt + OCP_W'(1);
      end
   end

   // Only logic clear or a full reset releases it
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act) begin
         fault <= 1'b0;
      end else if (ocp_cnt == OCP_END) begin
         fault <= 1'b1;
      end
   end

   // ==========================================================
   // Chop state machine
   // ==========================================================
   wcc_state_t state;
   wcc_state_t next_state;
   logic past_mix;

   assign past_mix = (pwm_cnt >= MIX_POINT);

   always_comb begin
      next_state = state;
      case (state)
         WCC_ST_DRIVE: begin
            // Comparator is ignored until blanking ends
            if (blank_done && trip_s) begin
               if (decay_mode == WCC_DECAY_SLOW) begin
                  next_state = WCC_ST_SLOW;
               end else if (decay_mode == WCC_DECAY_MIXED && past_mix) begin
                  next_state = WCC_ST_SLOW;
               end else begin
                  next_state = WCC_ST_FAST;
               end
            end
         end
         WCC_ST_FAST: begin
            if (decay_mode == WCC_DECAY_MIXED && past_mix) begin
               next_state = WCC_ST_SLOW;
            end else if (zero_s) begin
               next_state = WCC_ST_OFF;
            end
         end
         WCC_ST_OFF: begin
            if (decay_mode == WCC_DECAY_MIXED && past_mix) begin
               next_state = WCC_ST_SLOW;
            end
         end
         WCC_ST_SLOW: begin
            next_state = WCC_ST_SLOW;
         end
         default: begin
            next_state = WCC_ST_OFF;
         end
      endcase
      // A new period always starts by driving
      if (period_start) begin
         next_state = WCC_ST_DRIVE;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act || !run) begin
         state <= WCC_ST_DRIVE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Switch decode and output registers
   // ==========================================================
   logic next_hs_a;
   logic next_ls_a;
   logic next_hs_b;
   logic next_ls_b;

   always_comb begin
      next_hs_a = 1'b0;
      next_ls_a = 1'b0;
      next_hs_b = 1'b0;
      next_ls_b = 1'b0;
      if (run && !en_rise) begin
         case (state)
            WCC_ST_DRIVE: begin
               next_hs_a = dir_s;
               next_ls_b = dir_s;
               next_hs_b = !dir_s;
               next_ls_a = !dir_s;
            end
            WCC_ST_FAST: begin
               next_hs_b = dir_s;
               next_ls_a = dir_s;
               next_hs_a = !dir_s;
               next_ls_b = !dir_s;
            end
            WCC_ST_SLOW: begin
               next_ls_a = 1'b1;
               next_ls_b = 1'b1;
            end
            default: begin
               next_ls_a = 1'b0;
            end
         endcase
      end
   end

   // Fault, clear or enable low leave every switch open
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act || fault) begin
         high_side_a_o <= 1'b0;
         low_side_a_o <= 1'b0;
         high_side_b_o <= 1'b0;
         low_side_b_o <= 1'b0;
      end else begin
         high_side_a_o <= next_hs_a;
         low_side_a_o <= next_ls_a;
         high_side_b_o <= next_hs_b;
         low_side_b_o <= next_ls_b;
      end
   end

   // Pin level follows the high side, enable follows either side
   assign winding_out_a_o = high_side_a_o;
   assign winding_out_a_oe_o = high_side_a_o | low_side_a_o;
   assign winding_out_b_o = high_side_b_o;
   assign winding_out_b_oe_o = high_side_b_o | low_side_b_o;

   // Open drain: only ever pulls low
   assign trip_flag_n_o = 1'b0;
   assign trip_flag_n_oe_o = fault;

   // ==========================================================
   // Reference scaling and status
   // ==========================================================
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act) begin
         ref_scale_pct_o <= PCT_RESET;
      end else begin
         ref_scale_pct_o <= wcc_level_pct(level_s);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || clear_act) begin
         chop_phase_o <= WCC_ST_DRIVE;
         blanking_o <= 1'b0;
         pwm_cycle_start_o <= 1'b0;
      end else begin
         chop_phase_o <= state;
         blanking_o <= run && (state == WCC_ST_DRIVE) && !blank_done;
         pwm_cycle_start_o <= period_start;
      end
   end

   assign decay_mode_o = decay_mode;

endmodule

// >>> src/wcc_sync.sv
module wcc_sync
   import wcc_pkg::*;
#(
   parameter int WIDTH = SYNC_W
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         stage1 <= WIDTH'(SYNC_RESET);
         sync_o <= WIDTH'(SYNC_RESET);
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule
